// ===== logic/block_guard_decode.sv
// Purpose: Maps the block-guard pair and an address to a protected flag.
// Assumes: A 64 KiB array split into four equal sectors.
// Notes:   Pure combinational lookup.
`default_nettype none

module block_guard_decode (
    input  wire logic        block_guard_hi_in,
    input  wire logic        block_guard_lo_in,
    input  wire logic [15:0] addr_in,
    output logic             addr_guarded_out
);

    always_comb begin
        case ({block_guard_hi_in, block_guard_lo_in})
            2'b00:   addr_guarded_out = 1'b0;                                         // [R2]
            2'b01:   addr_guarded_out = (addr_in >= eeprom_guard_pkg::QUARTER_BASE);  // [R2]
            2'b10:   addr_guarded_out = (addr_in >= eeprom_guard_pkg::HALF_BASE);     // [R2]
            default: addr_guarded_out = 1'b1;                                         // [R2]
        endcase
    end

endmodule : block_guard_decode

`default_nettype wire

// ===== logic/eeprom_guard_pkg.sv
// Purpose: Shared constants and types for the EEPROM protect and erase controller.
// Assumes: A 40 MHz core clock; all serial pins arrive asynchronously.
// Notes:   Every offset, bit position, opcode and timing count lives here.
`default_nettype none

package eeprom_guard_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 32'h0000_0019;
    // Self-timed cycle length in ns; a plain default, the part's figure is not known.
    localparam int unsigned ERASE_TIME_NS   = 32'h004C_4B40;
    localparam int unsigned STATUS_TIME_NS  = 32'h004C_4B40;
    localparam int unsigned ERASE_CYCLES    = ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned STATUS_CYCLES   = STATUS_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W         = 32'h0000_0018;

    // ------------------------------------------------------------------
    // Opcodes and frame lengths
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0]  OP_LATCH_SET    = 8'h06;
    localparam logic [7:0]  OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0]  OP_PAGE_ERASE   = 8'h42;
    localparam logic [7:0]  OP_SECTOR_ERASE = 8'hD8;
    localparam logic [5:0]  BITS_OPCODE     = 6'h08;
    localparam logic [5:0]  BITS_STATUS     = 6'h10;
    localparam logic [5:0]  BITS_ADDRESSED  = 6'h18;
    localparam logic [5:0]  BITS_SATURATE   = 6'h3F;
    localparam int unsigned SHIFT_W         = 32'h0000_0018;

    // ------------------------------------------------------------------
    // Status byte layout
    // ------------------------------------------------------------------
    localparam int unsigned ST_PIN_GUARD    = 32'h0000_0007;
    localparam int unsigned ST_BLOCK_HI     = 32'h0000_0003;
    localparam int unsigned ST_BLOCK_LO     = 32'h0000_0002;
    localparam int unsigned ST_WRITE_LATCH  = 32'h0000_0001;
    localparam int unsigned ST_WRITE_BUSY   = 32'h0000_0000;
    localparam logic [7:0]  ST_WRITABLE     = 8'h8C;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W          = 32'h0000_0010;
    localparam logic [15:0] PAGE_MASK       = 16'hFF80;
    localparam logic [15:0] SECTOR_MASK     = 16'hC000;
    localparam logic [15:0] QUARTER_BASE    = 16'hC000;
    localparam logic [15:0] HALF_BASE       = 16'h8000;
    localparam logic [7:0]  ERASE_FILL      = 8'hFF;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PH_IDLE, PH_STATUS, PH_ERASE} phase_e;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic       si;
        logic       wp_n;
    } pins_s;

    localparam pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};

    typedef struct packed {
        logic        valid;
        logic [15:0] first;
        logic [15:0] last;
        logic [7:0]  fill;
    } erase_req_s;

    typedef struct packed {
        phase_e               phase;
        logic                 active;
        logic                 cs_prev;
        logic                 sck_prev;
        logic [SHIFT_W-1:0]   shift;
        logic [5:0]           count;
        logic [7:0]           status;
        logic [TIMER_W-1:0]   timer;
        erase_req_s           erase;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{
        phase: PH_IDLE, active: 1'b0, cs_prev: 1'b1, sck_prev: 1'b0,
        shift: '0, count: '0, status: STATUS_RESET, timer: '0, erase: '0};

endpackage : eeprom_guard_pkg

`default_nettype wire

// ===== logic/eeprom_protect_erase_ctrl.sv
// Purpose: Serial command front end for status writes, latch control and erases.
// Assumes: Pins are asynchronous and sampled at 40 MHz; the serial clock is far slower.
// Notes:   The array itself sits outside; erases leave as a one-cycle request.
`default_nettype none

// Contract
// (R1) Status write touches only guard and block bits
// (R2) Block pair selects none, quarter, half, all
// (R3) Pin guard active when pin low, enable set
// (R4) Pin guard inactive if pin high or disabled
// (R5) Pin guard blocks only status writes
// (R6) Latch needed; protected blocks never writable
// (R7) Latch clear at power-up, set by command
// (R8) Latch clears after write or status write
// (R9) Host ends frame after exact bit count
// (R10) Commands ignored while internal cycle runs
// (R11) Power-up: deselected, serial output released
// (R12) Inactive until first select falling edge
// (R13) Latch set only after exactly eight bits
// (R14) Page erase fills ones, needs latch
// (R15) Page erase: opcode then two address bytes
// (R16) Select rise after address starts erase
// (R17) Page erase into guarded block aborts
// (R18) Sector erase fills ones, needs latch
// (R19) Sector erase: opcode then two address bytes
// (R20) Select rise after address starts sector erase
// (R21) Sector erase into guarded block aborts
// (R22) Opcodes 01, 06, 42, D8 hex
// (R23) Status byte: guard 7, blocks 3:2, latch, busy
// (R24) Page is 128 aligned bytes
// (R25) Sector from top address bits; busy throughout
// (R26) Latch clears after successful erase
module eeprom_protect_erase_ctrl #(
    parameter int unsigned ERASE_CYCLES  = eeprom_guard_pkg::ERASE_CYCLES,
    parameter int unsigned STATUS_CYCLES = eeprom_guard_pkg::STATUS_CYCLES
) (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rstn_in,
    input  wire logic                         cs_n_in,
    input  wire logic                         sck_in,
    input  wire logic                         si_in,
    input  wire logic                         wp_n_in,
    input  wire logic                         write_done_in,
    output logic                              so_out,
    output logic                              so_oe_n_out,
    output logic [7:0]                        status_out,
    output logic                              pin_guard_active_out,
    output eeprom_guard_pkg::erase_req_s      erase_out
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    eeprom_guard_pkg::pins_s pins_raw;
    eeprom_guard_pkg::pins_s pins;

    assign pins_raw = '{cs_n: cs_n_in, sck: sck_in, si: si_in, wp_n: wp_n_in};

    pin_sync #(
        .WIDTH     (4),
        .RESET_VAL (eeprom_guard_pkg::PINS_IDLE)
    ) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (pins_raw),
        .sync_out   (pins)
    );

    // ------------------------------------------------------------------
    // State and derived terms
    // ------------------------------------------------------------------
    eeprom_guard_pkg::ctrl_s ctrl_reg;
    eeprom_guard_pkg::ctrl_s ctrl_next;

    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        pin_guard;
    logic        latch;
    logic        idle;
    logic        status_ok;
    logic        addr_guarded;
    logic [15:0] frame_addr;
    logic [7:0]  frame_data;

    // Edges are found on the synchronised copies, so each serial edge is seen once.
    assign cs_fall  = ctrl_reg.cs_prev & ~pins.cs_n;
    assign cs_rise  = ~ctrl_reg.cs_prev & pins.cs_n;
    assign sck_rise = ~ctrl_reg.sck_prev & pins.sck & ~pins.cs_n;

    assign pin_guard  = ctrl_reg.status[eeprom_guard_pkg::ST_PIN_GUARD] & ~pins.wp_n; // [R3] [R4]
    assign latch      = ctrl_reg.status[eeprom_guard_pkg::ST_WRITE_LATCH];
    assign idle       = (ctrl_reg.phase == eeprom_guard_pkg::PH_IDLE);
    assign status_ok  = latch & ~pin_guard;                                       // [R6] [R5]
    assign frame_addr = ctrl_reg.shift[15:0];                                     // [R15] [R19]
    assign frame_data = ctrl_reg.shift[7:0];

    block_guard_decode u_block_guard_decode (
        .block_guard_hi_in (ctrl_reg.status[eeprom_guard_pkg::ST_BLOCK_HI]),
        .block_guard_lo_in (ctrl_reg.status[eeprom_guard_pkg::ST_BLOCK_LO]),
        .addr_in           (frame_addr),
        .addr_guarded_out  (addr_guarded)
    );

    // ------------------------------------------------------------------
    // Frame matching
    // ------------------------------------------------------------------
    // A frame counts only if it ended on exactly the bit count of its command;
    // the opcode then sits in the eight bits shifted in first.
    function automatic logic frame_is(
        input logic [eeprom_guard_pkg::SHIFT_W-1:0] sh,
        input logic [5:0]                           n,
        input logic [7:0]                           op,
        input logic [5:0]                           bits
    );
        logic [7:0] code;
        code = '0;
        if (bits == eeprom_guard_pkg::BITS_ADDRESSED) begin
            code = sh[23:16];
        end else if (bits == eeprom_guard_pkg::BITS_STATUS) begin
            code = sh[15:8];
        end else begin
            code = sh[7:0];
        end
        return (n == bits) && (code == op);
    endfunction : frame_is

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_next             = ctrl_reg;
        ctrl_next.cs_prev     = pins.cs_n;
        ctrl_next.sck_prev    = pins.sck;
        ctrl_next.erase.valid = 1'b0;

        // Nothing is decoded until the host has selected the part once.
        if (cs_fall) begin
            ctrl_next.active = 1'b1;                                              // [R12]
            ctrl_next.count  = '0;
        end

        if (sck_rise && ctrl_reg.active) begin
            ctrl_next.shift = {ctrl_reg.shift[eeprom_guard_pkg::SHIFT_W-2:0], pins.si};
            if (ctrl_reg.count != eeprom_guard_pkg::BITS_SATURATE) begin
                ctrl_next.count = ctrl_reg.count + 6'h01;
            end
        end

        // --------------------------------------------------------------
        // Internal cycle timer
        // --------------------------------------------------------------
        case (ctrl_reg.phase)
            eeprom_guard_pkg::PH_STATUS: begin
                if (ctrl_reg.timer == '0) begin
                    ctrl_next.phase = eeprom_guard_pkg::PH_IDLE;
                    ctrl_next.status[eeprom_guard_pkg::ST_WRITE_LATCH] = 1'b0;   // [R8]
                end else begin
                    ctrl_next.timer = ctrl_reg.timer - 1'b1;
                end
            end
            eeprom_guard_pkg::PH_ERASE: begin
                if (ctrl_reg.timer == '0) begin
                    ctrl_next.phase = eeprom_guard_pkg::PH_IDLE;
                    ctrl_next.status[eeprom_guard_pkg::ST_WRITE_LATCH] = 1'b0;   // [R26]
                end else begin
                    ctrl_next.timer = ctrl_reg.timer - 1'b1;
                end
            end
            default: begin
            end
        endcase

        // The external byte or page write path reports its own completion.
        if (write_done_in) begin
            ctrl_next.status[eeprom_guard_pkg::ST_WRITE_LATCH] = 1'b0;           // [R8]
        end

        // --------------------------------------------------------------
        // Command execution on the rising select edge
        // --------------------------------------------------------------
        // While an internal cycle runs every frame is dropped, so the cycle
        // cannot be cut short or re-armed from the bus.
        if (cs_rise && ctrl_reg.active && idle) begin                            // [R10]
            if (frame_is(ctrl_reg.shift, ctrl_reg.count, eeprom_guard_pkg::OP_LATCH_SET,
                         eeprom_guard_pkg::BITS_OPCODE)) begin                    // [R13] [R22] [R9]
                ctrl_next.status[eeprom_guard_pkg::ST_WRITE_LATCH] = 1'b1;       // [R7]
            end else if (frame_is(ctrl_reg.shift, ctrl_reg.count,
                                  eeprom_guard_pkg::OP_LATCH_CLEAR,
                                  eeprom_guard_pkg::BITS_OPCODE)) begin
                ctrl_next.status[eeprom_guard_pkg::ST_WRITE_LATCH] = 1'b0;
            end else if (frame_is(ctrl_reg.shift, ctrl_reg.count,
                                  eeprom_guard_pkg::OP_STATUS_WRITE,
                                  eeprom_guard_pkg::BITS_STATUS)) begin            // [R22] [R9]
                if (status_ok) begin                                             // [R6] [R5]
                    // Only the guard-enable and block bits take the new byte.
                    ctrl_next.status = (ctrl_reg.status & ~eeprom_guard_pkg::ST_WRITABLE)
                                     | (frame_data & eeprom_guard_pkg::ST_WRITABLE); // [R1] [R23]
                    ctrl_next.phase  = eeprom_guard_pkg::PH_STATUS;
                    ctrl_next.timer  = eeprom_guard_pkg::TIMER_W'(STATUS_CYCLES - 1);
                end
            end else if (frame_is(ctrl_reg.shift, ctrl_reg.count,
                                  eeprom_guard_pkg::OP_PAGE_ERASE,
                                  eeprom_guard_pkg::BITS_ADDRESSED)) begin         // [R16] [R22]
                // The pin guard has no say here; only block guards stop an erase.
                if (latch && !addr_guarded) begin                                // [R14] [R17] [R5]
                    ctrl_next.erase.valid = 1'b1;                                // [R16]
                    ctrl_next.erase.first = frame_addr & eeprom_guard_pkg::PAGE_MASK;   // [R24]
                    ctrl_next.erase.last  = frame_addr | ~eeprom_guard_pkg::PAGE_MASK;  // [R24]
                    ctrl_next.erase.fill  = eeprom_guard_pkg::ERASE_FILL;        // [R14]
                    ctrl_next.phase       = eeprom_guard_pkg::PH_ERASE;          // [R25]
                    ctrl_next.timer       = eeprom_guard_pkg::TIMER_W'(ERASE_CYCLES - 1);
                end
            end else if (frame_is(ctrl_reg.shift, ctrl_reg.count,
                                  eeprom_guard_pkg::OP_SECTOR_ERASE,
                                  eeprom_guard_pkg::BITS_ADDRESSED)) begin         // [R20] [R22]
                // Any address in the sector is accepted; the erase starts from its base.
                if (latch && !addr_guarded) begin                                // [R18] [R21]
                    ctrl_next.erase.valid = 1'b1;                                // [R20]
                    ctrl_next.erase.first = frame_addr & eeprom_guard_pkg::SECTOR_MASK; // [R25]
                    ctrl_next.erase.last  = frame_addr | ~eeprom_guard_pkg::SECTOR_MASK;
                    ctrl_next.erase.fill  = eeprom_guard_pkg::ERASE_FILL;        // [R18]
                    ctrl_next.phase       = eeprom_guard_pkg::PH_ERASE;          // [R25]
                    ctrl_next.timer       = eeprom_guard_pkg::TIMER_W'(ERASE_CYCLES - 1);
                end
            end
        end

        // Busy mirrors the phase, so it is set from the first cycle of a run
        // and falls in the same cycle the latch is released.
        ctrl_next.status[eeprom_guard_pkg::ST_WRITE_BUSY] =
            (ctrl_next.phase != eeprom_guard_pkg::PH_IDLE);                      // [R25] [R16] [R20]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_reg <= eeprom_guard_pkg::CTRL_RESET;                            // [R7] [R11] [R12]
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Read paths are not part of this block, so the serial output is never driven.
    assign so_out               = 1'b0;
    assign so_oe_n_out          = 1'b1;                                          // [R11]
    assign status_out           = ctrl_reg.status;                               // [R23]
    assign pin_guard_active_out = pin_guard;                                     // [R3] [R4]
    assign erase_out            = ctrl_reg.erase;

endmodule : eeprom_protect_erase_ctrl

`default_nettype wire

// ===== logic/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level; no bus coherency is promised.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module pin_sync #(
    parameter int unsigned        WIDTH     = 4,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pin_sync

`default_nettype wire

// ===== test/eeprom_guard_props.sv
// Purpose: Port checker for the protect and erase controller.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Bound onto every instance of the controller.
`default_nettype none
module eeprom_guard_props #(
    parameter int unsigned ERASE_CYCLES  = 20,
    parameter int unsigned STATUS_CYCLES = 20
) (
    input wire logic                         ref_clk_in,
    input wire logic                         rstn_in,
    input wire logic                         wp_n_in,
    input wire logic                         so_oe_n_out,
    input wire logic [7:0]                   status_out,
    input wire logic                         pin_guard_active_out,
    input wire eeprom_guard_pkg::erase_req_s erase_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    valid_one_shot_a: assert property (erase_out.valid |=> !erase_out.valid)
        else $error("erase request held longer than one cycle");
    erase_fill_a: assert property (erase_out.valid |-> erase_out.fill == 8'hFF)
        else $error("erase fill is not all ones");
    erase_span_a: assert property (erase_out.valid |->
        (erase_out.last - erase_out.first == 16'h007F && erase_out.first[6:0] == 7'h00) ||
        (erase_out.last - erase_out.first == 16'h3FFF && erase_out.first[13:0] == 14'h0000))
        else $error("erase span is neither a page nor a sector");
    busy_with_erase_a: assert property (erase_out.valid |-> status_out[0])
        else $error("erase started without busy");
    guard_block_a: assert property (erase_out.valid |->
        !(status_out[3] && erase_out.first[15]) && status_out[3:2] != 2'b11 &&
        !(status_out[2] && erase_out.first[15:14] == 2'b11))
        else $error("erase issued into a guarded block");
    guard_on_a: assert property ($past(rstn_in, 3) && !$past(wp_n_in, 2) &&
        !$past(wp_n_in, 3) |-> pin_guard_active_out == status_out[7])
        else $error("pin guard does not follow enable bit");
    guard_off_a: assert property ($past(rstn_in, 3) && $past(wp_n_in, 2) &&
        $past(wp_n_in, 3) |-> !pin_guard_active_out)
        else $error("pin guard active with pin high");
    latch_clear_end_a: assert property ($fell(status_out[0]) |-> !status_out[1])
        else $error("write latch kept after self-timed cycle");
    quiet_pins_a: assert property (status_out[6:4] == 3'b000 && so_oe_n_out)
        else $error("spare status bits or serial output driven");

    cover property (erase_out.valid);
    cover property ($fell(status_out[0]));
    cover property (pin_guard_active_out);
endmodule : eeprom_guard_props

bind eeprom_protect_erase_ctrl eeprom_guard_props #(
    .ERASE_CYCLES(ERASE_CYCLES), .STATUS_CYCLES(STATUS_CYCLES)) eeprom_guard_props_inst (
    .ref_clk_in, .rstn_in, .wp_n_in, .so_oe_n_out, .status_out, .pin_guard_active_out,
    .erase_out);
`default_nettype wire

// ===== test/serial_host.sv
// Purpose: Behavioural serial host that frames commands for the controller.
// Assumes: One serial bit spans eight core clocks, a 200 ns link period.
// Notes:   Outside frames the data line toggles, so a stale bit is never seen as valid.
`default_nettype none
module serial_host (
    input  wire logic ref_clk_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic idle_reg = 1'b1;

    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end

    always @(posedge ref_clk_in) begin
        if (idle_reg) si_out <= ~si_out;
    end

    // Sends the top n bits of d, most significant first; call just after a clock edge.
    // A count that misses the command length is sent on purpose to be refused.
    task automatic frame(input logic [23:0] d, input int n);
        idle_reg <= 1'b0;
        cs_n_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        for (int i = 0; i < n; i++) begin
            sck_out <= 1'b0;
            si_out <= d[23-i];
            repeat (4) @(posedge ref_clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
        end
        sck_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        idle_reg <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
    endtask : frame
endmodule : serial_host
`default_nettype wire

// ===== test/testbench.sv
// Purpose: Self-checking bench for the protect and erase controller.
// Assumes: Busy times shortened through the top parameters.
// Notes:   Erase busy is long enough for a whole frame to land inside it.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                         ref_clk_in    = 1'b0;
    logic                         rstn_in       = 1'b0;
    logic                         wp_n_in       = 1'b1;
    logic                         write_done_in = 1'b0;
    logic                         cs_n, sck, si, so, so_oe_n, guard;
    logic [7:0]                   status;
    eeprom_guard_pkg::erase_req_s erase;
    eeprom_guard_pkg::erase_req_s last_erase = '0;
    int                           n_erase    = 0;
    int                           fail_count = 0;
    int                           n_checks   = 0;

    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        if (erase.valid === 1'b1) begin
            last_erase <= erase;
            n_erase <= n_erase + 1;
        end
    end

    serial_host serial_host_inst (.ref_clk_in, .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
    eeprom_protect_erase_ctrl #(.ERASE_CYCLES(120), .STATUS_CYCLES(20))
        eeprom_protect_erase_ctrl_inst (.ref_clk_in, .rstn_in, .cs_n_in(cs_n), .sck_in(sck),
        .si_in(si), .wp_n_in, .write_done_in, .so_out(so), .so_oe_n_out(so_oe_n),
        .status_out(status), .pin_guard_active_out(guard), .erase_out(erase));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic check_erase(input int n, input logic [15:0] f, input logic [15:0] l);
        n_checks++;
        if (n_erase != n || {last_erase.first, last_erase.last} !== {f, l}) begin
            fail_count++;
            $display("BAD %0t erase %0d %h-%h expected %0d %h-%h", $time, n_erase,
                     last_erase.first, last_erase.last, n, f, l);
        end
    endtask : check_erase

    task automatic wait_idle;
        int k;
        for (k = 0; k < 400 && status[0] !== 1'b0; k++) @(posedge ref_clk_in);
        if (k == 400) begin
            fail_count++;
            $display("BAD %0t busy never cleared", $time);
            end_of_test();
        end
    endtask : wait_idle

    task automatic cmd(input logic [23:0] d, input int n);
        serial_host_inst.frame(d, n);
        repeat (3) @(posedge ref_clk_in);
        wait_idle();
    endtask : cmd

    initial begin
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        check8(status, 8'h00);
        check8({so_oe_n, guard, erase.valid, so, 4'h0}, 8'h80);
        cmd(24'h42_1234, 24);
        check_erase(0, 16'h0000, 16'h0000);
        cmd(24'h06_0000, 9);
        check8(status, 8'h00);
        cmd(24'h06_0000, 8);
        check8(status, 8'h02);
        cmd(24'h04_0000, 8);
        check8(status, 8'h00);
        cmd(24'h01_8C00, 16);
        check8(status, 8'h00);
        cmd(24'h06_0000, 8);
        write_done_in <= 1'b1;
        @(posedge ref_clk_in);
        write_done_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        check8(status, 8'h00);
        cmd(24'h06_0000, 8);
        serial_host_inst.frame(24'h42_1234, 24);
        repeat (3) @(posedge ref_clk_in);
        check8(status, 8'h03);
        // A latch set sent while busy is dropped, but the erase end clears the latch either way.
        serial_host_inst.frame(24'h06_0000, 8);
        wait_idle();
        check8(status, 8'h00);
        check_erase(1, 16'h1200, 16'h127F);
        cmd(24'h06_0000, 8);
        cmd(24'hD8_9ABC, 24);
        check_erase(2, 16'h8000, 16'hBFFF);
        cmd(24'h06_0000, 8);
        cmd(24'h01_F400, 16);
        check8(status, 8'h84);
        wp_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        check8({7'h00, guard}, 8'h01);
        cmd(24'h06_0000, 8);
        cmd(24'h01_0000, 16);
        check8(status, 8'h86);
        cmd(24'h42_0100, 24);
        check_erase(3, 16'h0100, 16'h017F);
        cmd(24'h06_0000, 8);
        cmd(24'h42_C000, 24);
        check_erase(3, 16'h0100, 16'h017F);
        cmd(24'hD8_F000, 24);
        check_erase(3, 16'h0100, 16'h017F);
        wp_n_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        check8({7'h00, guard}, 8'h00);
        cmd(24'h01_0800, 16);
        check8(status, 8'h08);
        cmd(24'h06_0000, 8);
        cmd(24'h42_7F80, 24);
        check_erase(4, 16'h7F80, 16'h7FFF);
        cmd(24'h06_0000, 8);
        cmd(24'h42_8000, 24);
        check_erase(4, 16'h7F80, 16'h7FFF);
        cmd(24'h01_0C00, 16);
        cmd(24'h06_0000, 8);
        cmd(24'hD8_0000, 24);
        check_erase(4, 16'h7F80, 16'h7FFF);
        check8(status, 8'h0E);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
